/* ocse_pkg.sv */
// constants, types and register map of the output channel sync and enable block
//
// Behaviour
// - glitchless update never shortens a high phase
// - glitchless change stretches the low phase
// - per-channel glitchless switching enable bit
// - alignment pin qualified on reference clock
// - sync low mutes outputs, holds dividers reset
// - sync release starts all sync-enabled dividers together
// - per-channel first edge delay, max 32
// - channels without sync enable keep running
// - select bit: pin is power-down or sync
// - global enable spares channel zero bypass
// - disabled output drives selected mute level
// - mute bit forces channel to mute level
// - enable gating lives inside running divider
// - enable change qualified by four output or internal cycles
// - disable: four more cycles, then mute
// - enable: resume after four internal cycles
// - channel zero enable and slew field
// - channels one, four: per-leg enable, invert
// - per-channel current-mode buffer enable
// - per-channel low-swing differential buffer enable
package ocse_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int NUM_REGS = 16;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 16;
  localparam int DIV_W    = 14;
  localparam int DLY_W    = 6;
  localparam int SLOT_W   = 4;

  // ---------------------------------------------------------------
  // register offsets, listed in slot order
  // ---------------------------------------------------------------
  localparam logic [0:NUM_REGS-1][ADDR_W-1:0] REG_OFS = '{
    7'h00, 7'h39, 7'h3B, 7'h3C, 7'h3F, 7'h41, 7'h42, 7'h44,
    7'h46, 7'h47, 7'h49, 7'h4B, 7'h4C, 7'h4D, 7'h4E, 7'h4F};
  localparam int SLOT_DEV_CTRL0 = 0;
  localparam int SLOT_CHAN0_SINGLE_ENDED_ON    = 14;
  localparam int SLOT_CH0_SLEW  = 15;
  localparam int CH_CTRL_SLOT [0:NUM_CHAN-1] = '{1, 4, 7, 10};
  localparam int CH_BUF_SLOT  [0:NUM_CHAN-1] = '{2, 5, 8, 11};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_PIN_IS_SYNC = 14;
  localparam int BIT_SYNC        = 5;
  localparam int BIT_CLEAN_SW    = 9;
  localparam int BIT_JOIN_ALIGN  = 3;
  localparam int BIT_SILENT_LVL  = 1;
  localparam int BIT_SILENCE     = 0;
  localparam int BIT_CH0_ON      = 12;
  localparam int SLEW_LSB        = 0;
  localparam int SLEW_W          = 4;
  localparam int CURRENT_MODE_BIT [0:NUM_CHAN-1] = '{14, 13, 13, 13};
  localparam int LOW_SWING_BIT    [0:NUM_CHAN-1] = '{15, 11, 11, 15};
  localparam logic [NUM_CHAN-1:0] HAS_CMOS_LEGS  = 4'h9;
  localparam int POS_ON_BIT  [0:NUM_CHAN-1] = '{13, 0, 0, 14};
  localparam int NEG_ON_BIT  [0:NUM_CHAN-1] = '{14, 0, 0, 13};
  localparam int POS_INV_BIT [0:NUM_CHAN-1] = '{11, 0, 0, 12};
  localparam int NEG_INV_BIT [0:NUM_CHAN-1] = '{12, 0, 0, 11};

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] DEV_CTRL0_RST = 16'h4020;
  localparam logic [DATA_W-1:0] REG_RST       = 16'h0000;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [2:0]       OE_QUAL_CYCLES = 3'h4;
  localparam logic [DLY_W-1:0] SYNC_DELAY_MAX = 6'h20;
  localparam logic [DIV_W-1:0] DIV_MIN        = 14'h0002;

  // ---------------------------------------------------------------
  // channel divider states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CH_HOLD    = 4'b0001,
    CH_DELAY   = 4'b0010,
    CH_RUN     = 4'b0100,
    CH_STRETCH = 4'b1000
  } ocse_chan_state_t;

endpackage

/* ocse_chan_if.sv */
// control and status bundle between the top and one divided channel
`timescale 1ns/1ps
interface ocse_chan_if;
  import ocse_pkg::*;

  logic [DIV_W-1:0] div_value;
  logic [DLY_W-1:0] sync_delay;
  logic             glitchless_en;
  logic             sync_en;
  logic             sync_hold;
  logic             oe_level;
  logic             mute;
  logic             mute_level;
  logic             out_level;
  logic             running;
  logic             oe_active;

  modport ctrl (
    output div_value, sync_delay, glitchless_en, sync_en, sync_hold,
    output oe_level, mute, mute_level,
    input  out_level, running, oe_active
  );
  modport chan (
    input  div_value, sync_delay, glitchless_en, sync_en, sync_hold,
    input  oe_level, mute, mute_level,
    output out_level, running, oe_active
  );
endinterface

/* ocse_channel.sv */
// one divided output channel: integer divider, sync, enable gating, mute
`timescale 1ns/1ps
module ocse_channel
  import ocse_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // prescaler period strobe
  input  wire logic presc_tick_i,
  // control and status
  ocse_chan_if.chan ch
);

  typedef struct packed {
    ocse_chan_state_t state;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] cur_div;
    logic [DLY_W-1:0] dly;
    logic             oe_active;
    logic [2:0]       oe_cnt;
    logic             clk_level;
    logic             out_level;
  } ocse_chan_reg_t;

  ocse_chan_reg_t   s_r;
  ocse_chan_reg_t   s_nxt;
  logic [DIV_W-1:0] eff_div;
  logic [DIV_W:0]   hi_sum;
  logic [DIV_W-1:0] hi_len;
  logic [DIV_W-1:0] cnt_inc;
  logic             at_end;
  logic             hold;
  logic             rise;
  logic             running;

  always_comb begin
    s_nxt   = s_r;
    eff_div = (ch.div_value < DIV_MIN) ? DIV_MIN : ch.div_value;
    hi_sum  = {1'b0, s_r.cur_div} + {{DIV_W{1'b0}}, 1'b1};
    hi_len  = hi_sum[DIV_W:1];
    cnt_inc = s_r.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    at_end  = (cnt_inc >= s_r.cur_div);
    hold    = ch.sync_en && ch.sync_hold;
    running = (s_r.state != CH_HOLD);
    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    if (!ch.glitchless_en) begin
      s_nxt.cur_div = eff_div;
    end
    case (s_r.state)
      CH_HOLD: begin
        s_nxt.cnt       = '0;
        s_nxt.clk_level = 1'b0;
        s_nxt.cur_div   = eff_div;
        s_nxt.dly       = (ch.sync_delay > SYNC_DELAY_MAX) ? SYNC_DELAY_MAX : ch.sync_delay;
        if (!hold) begin
          if (s_nxt.dly == '0) begin
            s_nxt.state     = CH_RUN;
            s_nxt.clk_level = 1'b1;
          end else begin
            s_nxt.state = CH_DELAY;
          end
        end
      end
      CH_DELAY: begin
        if (presc_tick_i) begin
          s_nxt.dly = s_r.dly - {{(DLY_W-1){1'b0}}, 1'b1};
          if (s_r.dly == {{(DLY_W-1){1'b0}}, 1'b1}) begin
            s_nxt.state     = CH_RUN;
            s_nxt.clk_level = 1'b1;
            s_nxt.cnt       = '0;
          end
        end
      end
      CH_RUN: begin
        if (presc_tick_i) begin
          if (at_end) begin
            s_nxt.cnt = '0;
            if (ch.glitchless_en && (eff_div != s_r.cur_div)) begin
              s_nxt.state     = CH_STRETCH;
              s_nxt.clk_level = 1'b0;
              s_nxt.cur_div   = eff_div;
            end else begin
              s_nxt.clk_level = 1'b1;
            end
          end else begin
            s_nxt.cnt       = cnt_inc;
            s_nxt.clk_level = (cnt_inc < hi_len);
          end
        end
      end
      CH_STRETCH: begin
        if (presc_tick_i) begin
          s_nxt.state     = CH_RUN;
          s_nxt.cnt       = '0;
          s_nxt.clk_level = 1'b1;
        end
      end
      default: begin
        s_nxt.state = CH_HOLD;
      end
    endcase
    if (hold) begin
      s_nxt.state     = CH_HOLD;
      s_nxt.cnt       = '0;
      s_nxt.clk_level = 1'b0;
    end
    // ---------------------------------------------------------------
    // enable qualification, counted only while the divider runs
    // ---------------------------------------------------------------
    rise = s_nxt.clk_level && !s_r.clk_level;
    if (ch.oe_level == s_r.oe_active) begin
      s_nxt.oe_cnt = '0;
    end else if (running) begin
      if (s_r.oe_cnt == OE_QUAL_CYCLES) begin
        if (!s_nxt.clk_level) begin
          s_nxt.oe_active = ch.oe_level;
          s_nxt.oe_cnt    = '0;
        end
      end else if (s_r.oe_active ? rise : presc_tick_i) begin
        s_nxt.oe_cnt = s_r.oe_cnt + 3'h1;
      end
    end
    // ---------------------------------------------------------------
    // output level
    // ---------------------------------------------------------------
    if ((s_nxt.state == CH_HOLD) || (s_nxt.state == CH_DELAY) || ch.mute
        || !s_nxt.oe_active) begin
      s_nxt.out_level = ch.mute_level;
    end else begin
      s_nxt.out_level = s_nxt.clk_level;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_r           <= '0;
      s_r.state     <= CH_HOLD;
      s_r.cur_div   <= DIV_MIN;
      s_r.oe_active <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ch.out_level = s_r.out_level;
  assign ch.running   = running;
  assign ch.oe_active = s_r.oe_active;

endmodule

/* ocse_top.sv */
// output channel control: registers, sync qualification, buffers, channels
`timescale 1ns/1ps
module ocse_top
  import ocse_pkg::*;
(
  // clock and reset
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_i,
  // register port
  input  wire logic [ADDR_W-1:0]                reg_addr_i,
  input  wire logic [DATA_W-1:0]                reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic      [DATA_W-1:0]                reg_rdata_o,
  output logic                                  reg_rvalid_o,
  // clock strobes and reference copy
  input  wire logic                             ref_tick_i,
  input  wire logic                             prescaler_a_tick_i,
  input  wire logic                             ref_bypass_i,
  // shared power-down / alignment pin
  input  wire logic                             alignment_pin_active_low_i,
  // enables and per-channel settings
  input  wire logic                             global_oe_i,
  input  wire logic [NUM_CHAN-1:0]              chan_oe_i,
  input  wire logic [NUM_CHAN-1:0][DIV_W-1:0]   channel_integer_divider_i,
  input  wire logic [NUM_CHAN-1:0][DLY_W-1:0]   channel_first_edge_delay_i,
  // channel zero
  output logic                                  out0_o,
  output logic                                  chan0_single_ended_on_o,
  output logic      [SLEW_W-1:0]                chan0_slew_field_o,
  // divided channels
  output logic      [NUM_CHAN-1:0]              chan_pos_o,
  output logic      [NUM_CHAN-1:0]              chan_neg_o,
  output logic      [NUM_CHAN-1:0]              pos_leg_on_o,
  output logic      [NUM_CHAN-1:0]              neg_leg_on_o,
  output logic      [NUM_CHAN-1:0]              current_mode_on_o,
  output logic      [NUM_CHAN-1:0]              low_swing_diff_on_o,
  // status
  output logic                                  power_down_o,
  output logic                                  sync_hold_o,
  output logic      [NUM_CHAN-1:0]              chan_running_o,
  output logic      [NUM_CHAN-1:0]              chan_oe_active_o
);

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0]               rdata;
    logic                            rvalid;
    logic                            pin_samp;
    logic                            pin_qual;
    logic                            sync_hold;
    logic [NUM_CHAN-1:0]             pos;
    logic [NUM_CHAN-1:0]             neg;
    logic                            out0;
  } ocse_top_reg_t;

  ocse_top_reg_t             s_r;
  ocse_top_reg_t             s_nxt;
  logic [SLOT_W:0]           hit;
  logic [NUM_CHAN-1:0]       chan_level;
  logic [NUM_CHAN-1:0]       pos_inv;
  logic [NUM_CHAN-1:0]       neg_inv;
  logic [DATA_W-1:0]         ctrl0;

  // ---------------------------------------------------------------
  // address decode: valid flag and slot number
  // ---------------------------------------------------------------
  function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] addr);
    logic [SLOT_W:0] res;
    res = '0;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (REG_OFS[k] == addr) begin
        res = {1'b1, SLOT_W'(k)};
      end
    end
    return res;
  endfunction

  assign ctrl0 = s_r.regs[SLOT_DEV_CTRL0];

  always_comb begin
    s_nxt        = s_r;
    hit          = slot_of(reg_addr_i);
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    s_nxt.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      s_nxt.rdata = hit[SLOT_W] ? s_r.regs[hit[SLOT_W-1:0]] : REG_RST;
    end
    if (reg_wr_i && hit[SLOT_W]) begin
      s_nxt.regs[hit[SLOT_W-1:0]] = reg_wdata_i;
    end
    // ---------------------------------------------------------------
    // pin qualification on the reference clock
    // ---------------------------------------------------------------
    if (ref_tick_i) begin
      s_nxt.pin_samp = alignment_pin_active_low_i;
      if (alignment_pin_active_low_i == s_r.pin_samp) begin
        s_nxt.pin_qual = alignment_pin_active_low_i;
      end
    end
    s_nxt.sync_hold = (ctrl0[BIT_PIN_IS_SYNC] && !s_r.pin_qual) || !ctrl0[BIT_SYNC];
    // ---------------------------------------------------------------
    // output legs and bypass copy
    // ---------------------------------------------------------------
    for (int c = 0; c < NUM_CHAN; c++) begin
      s_nxt.pos[c] = chan_level[c] ^ pos_inv[c];
      s_nxt.neg[c] = ~chan_level[c] ^ neg_inv[c];
    end
    s_nxt.out0 = s_r.regs[SLOT_CHAN0_SINGLE_ENDED_ON][BIT_CH0_ON] && ref_bypass_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_r                      <= '0;
      s_r.regs[SLOT_DEV_CTRL0] <= DEV_CTRL0_RST;
      s_r.pin_samp             <= 1'b1;
      s_r.pin_qual             <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // divided channels
  // ---------------------------------------------------------------
  ocse_chan_if chan_bus [NUM_CHAN] ();

  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      localparam int CS = CH_CTRL_SLOT[c];
      localparam int BS = CH_BUF_SLOT[c];

      assign chan_bus[c].div_value     = channel_integer_divider_i[c];
      assign chan_bus[c].sync_delay    = channel_first_edge_delay_i[c];
      assign chan_bus[c].glitchless_en = s_r.regs[CS][BIT_CLEAN_SW];
      assign chan_bus[c].sync_en       = s_r.regs[CS][BIT_JOIN_ALIGN];
      assign chan_bus[c].sync_hold     = s_r.sync_hold;
      assign chan_bus[c].oe_level      = chan_oe_i[c] && global_oe_i;
      assign chan_bus[c].mute          = s_r.regs[CS][BIT_SILENCE];
      assign chan_bus[c].mute_level    = s_r.regs[CS][BIT_SILENT_LVL];

      assign chan_level[c]          = chan_bus[c].out_level;
      assign chan_running_o[c]      = chan_bus[c].running;
      assign chan_oe_active_o[c]    = chan_bus[c].oe_active;
      assign current_mode_on_o[c]   = s_r.regs[CS][CURRENT_MODE_BIT[c]];
      assign low_swing_diff_on_o[c] = s_r.regs[BS][LOW_SWING_BIT[c]];

      if (HAS_CMOS_LEGS[c]) begin : g_cmos
        assign pos_leg_on_o[c] = s_r.regs[BS][POS_ON_BIT[c]];
        assign neg_leg_on_o[c] = s_r.regs[BS][NEG_ON_BIT[c]];
        assign pos_inv[c]      = s_r.regs[BS][POS_INV_BIT[c]];
        assign neg_inv[c]      = s_r.regs[BS][NEG_INV_BIT[c]];
      end else begin : g_diff
        assign pos_leg_on_o[c] = 1'b0;
        assign neg_leg_on_o[c] = 1'b0;
        assign pos_inv[c]      = 1'b0;
        assign neg_inv[c]      = 1'b0;
      end

      ocse_channel u_chan (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .presc_tick_i (prescaler_a_tick_i),
        .ch           (chan_bus[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o             = s_r.rdata;
  assign reg_rvalid_o            = s_r.rvalid;
  assign out0_o                  = s_r.out0;
  assign chan0_single_ended_on_o = s_r.regs[SLOT_CHAN0_SINGLE_ENDED_ON][BIT_CH0_ON];
  assign chan0_slew_field_o      = s_r.regs[SLOT_CH0_SLEW][SLEW_LSB +: SLEW_W];
  assign chan_pos_o              = s_r.pos;
  assign chan_neg_o              = s_r.neg;
  assign power_down_o            = !ctrl0[BIT_PIN_IS_SYNC] && !s_r.pin_qual;
  assign sync_hold_o             = s_r.sync_hold;

endmodule

/* ocse_rx_model.sv */
// downstream clock receiver: edge counts and phase widths per channel
`timescale 1ns/1ps
module ocse_rx_model
  import ocse_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  // received clocks
  input  wire logic [NUM_CHAN-1:0]       clk_in_i,
  // observations
  output logic      [NUM_CHAN-1:0][15:0] rises_o,
  output logic      [NUM_CHAN-1:0][15:0] hi_len_o,
  output logic      [NUM_CHAN-1:0][15:0] lo_len_o
);
  logic [NUM_CHAN-1:0]       prev_r;
  logic [NUM_CHAN-1:0][15:0] run_r;

  // width of a phase is counted in samples at one level
  always_ff @(posedge clk_sys_i) begin
    prev_r <= clk_in_i;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (rst_i) begin
        rises_o[c]  <= 16'h0000;
        hi_len_o[c] <= 16'h0000;
        lo_len_o[c] <= 16'h0000;
        run_r[c]    <= 16'h0000;
      end else if (clk_in_i[c] != prev_r[c]) begin
        run_r[c] <= 16'h0001;
        if (clk_in_i[c]) begin
          rises_o[c]  <= rises_o[c] + 16'h0001;
          lo_len_o[c] <= run_r[c];
        end else begin
          hi_len_o[c] <= run_r[c];
        end
      end else begin
        run_r[c] <= run_r[c] + 16'h0001;
      end
    end
  end
endmodule

/* ocse_top_properties.sv */
// concurrent checks on the ports of the output channel control top
`timescale 1ns/1ps
module ocse_top_properties
  import ocse_pkg::*;
(
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic [ADDR_W-1:0]   reg_addr_i,
  input wire logic [DATA_W-1:0]   reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                ref_bypass_i,
  input wire logic                global_oe_i,
  input wire logic [NUM_CHAN-1:0] chan_oe_i,
  input wire logic                out0_o,
  input wire logic                chan0_single_ended_on_o,
  input wire logic [NUM_CHAN-1:0] chan_pos_o,
  input wire logic                sync_hold_o,
  input wire logic [NUM_CHAN-1:0] chan_running_o,
  input wire logic [NUM_CHAN-1:0] chan_oe_active_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // shadow of the first two channel control words
  // ---------------------------------------------------------------
  logic [15:0] c1_r;
  logic [15:0] c2_r;
  logic [1:0]  mcnt_r;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      c1_r   <= 16'h0000;
      c2_r   <= 16'h0000;
      mcnt_r <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_OFS[1]) c1_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == REG_OFS[4]) c2_r <= reg_wdata_i;
      if ((reg_wr_i && reg_addr_i == REG_OFS[4]) || !c2_r[0]) mcnt_r <= 2'h0;
      else if (mcnt_r != 2'h3) mcnt_r <= mcnt_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_ch0_bypass: assert property (
    !$past(rst_i) |-> out0_o == ($past(chan0_single_ended_on_o) && $past(ref_bypass_i)))
    else $error("channel zero output does not follow enable and bypass");
  chk_ch0_field: assert property (
    reg_wr_i && reg_addr_i == 7'h4E |=> chan0_single_ended_on_o == $past(reg_wdata_i[12]))
    else $error("channel zero enable does not follow its register");
  chk_mute_level: assert property (mcnt_r == 2'h3 |-> chan_pos_o[1] == c2_r[1])
    else $error("muted channel not at selected level");
  chk_hold_stops: assert property (
    sync_hold_o && c2_r[3] ##1 c2_r[3] |-> !chan_running_o[1])
    else $error("joined channel runs during hold");
  chk_free_runs: assert property (
    chan_running_o[1] && !c2_r[3] ##1 !c2_r[3] |-> chan_running_o[1])
    else $error("channel outside alignment was stopped");
  chk_release_together: assert property (
    c1_r[3] && c2_r[3] && $past(c1_r[3] && c2_r[3]) |-> chan_running_o[0] == chan_running_o[1])
    else $error("joined channels leave hold apart");
  chk_oe_rise_wait: assert property (
    !$past(rst_i) && $rose(chan_oe_active_o[1]) |->
      $past(chan_oe_i[1] && global_oe_i) && $past(chan_oe_i[1] && global_oe_i, 4))
    else $error("enable taken without a steady request");
  chk_oe_fall_wait: assert property (
    $fell(chan_oe_active_o[1]) |->
      !$past(chan_oe_i[1] && global_oe_i) && !$past(chan_oe_i[1] && global_oe_i, 4))
    else $error("disable taken without a steady request");

  cover property ($fell(sync_hold_o));
  cover property ($fell(chan_oe_active_o[1]));
  cover property (mcnt_r == 2'h3 && c2_r[1]);
endmodule

bind ocse_top ocse_top_properties i_props (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .ref_bypass_i, .global_oe_i, .chan_oe_i, .out0_o, .chan0_single_ended_on_o,
  .chan_pos_o, .sync_hold_o, .chan_running_o, .chan_oe_active_o);

/* ocse_top_tb_top.sv */
// self-checking bench of the output channel control top
`timescale 1ns/1ps
module ocse_top_tb_top;
  import ocse_pkg::*;

  logic clk_sys_i, reg_rvalid_o, out0, ch0_on, pd, hold;
  logic rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, ref_bypass_i = 1'b0;
  logic ref_tick_i = 1'b1, prescaler_a_tick_i = 1'b1, pin_n = 1'b1, global_oe_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 7'h00;
  logic [DATA_W-1:0] reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [NUM_CHAN-1:0] chan_oe_i = 4'hF, pos, neg, pl, nl, cm, ls, run, act;
  logic [NUM_CHAN-1:0][DIV_W-1:0] div = {14'h0008, 14'h0005, 14'h0004, 14'h0002};
  logic [NUM_CHAN-1:0][DLY_W-1:0] dly = {6'h00, 6'h00, 6'h3F, 6'h00};
  logic [SLEW_W-1:0] slew;
  logic [NUM_CHAN-1:0][15:0] rises, hi_len, lo_len, snap;
  logic [15:0] regs [0:NUM_REGS-1];
  logic [15:0] exp_q [$];
  int n_mismatch = 0, n_compared = 0, cyc = 0, k;
  int t [0:2];

  ocse_top i_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .ref_tick_i, .prescaler_a_tick_i, .ref_bypass_i,
    .alignment_pin_active_low_i(pin_n), .global_oe_i, .chan_oe_i,
    .channel_integer_divider_i(div), .channel_first_edge_delay_i(dly), .out0_o(out0),
    .chan0_single_ended_on_o(ch0_on), .chan0_slew_field_o(slew), .chan_pos_o(pos),
    .chan_neg_o(neg), .pos_leg_on_o(pl), .neg_leg_on_o(nl), .current_mode_on_o(cm),
    .low_swing_diff_on_o(ls), .power_down_o(pd), .sync_hold_o(hold),
    .chan_running_o(run), .chan_oe_active_o(act));

  ocse_rx_model i_rx (.clk_sys_i, .rst_i, .clk_in_i(pos), .rises_o(rises),
    .hi_len_o(hi_len), .lo_len_o(lo_len));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic wait_lvl(input int c, input logic v);
    for (int i = 0; i < 64 && pos[c] !== v; i++) @(posedge clk_sys_i);
  endtask

  // read data monitor, random bypass copy and run limit
  always @(posedge clk_sys_i) begin
    cyc++;
    ref_bypass_i <= 1'($urandom_range(0, 1));
    if (reg_rvalid_o === 1'b1) cmp_val(reg_rdata_o, exp_q.pop_front());
    if (cyc == 6000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h520F8A1C));
    tick(3);
    rst_i <= 1'b0;
    rd(7'h00, DEV_CTRL0_RST);
    for (int s = 1; s < NUM_REGS; s++) begin
      regs[s] = 16'($urandom());
      wr(REG_OFS[s], regs[s]);
    end
    wr(7'h10, 16'hFFFF);
    for (int s = 1; s < NUM_REGS; s++) rd(REG_OFS[s], regs[s]);
    rd(7'h10, 16'h0000);
    tick(3);
    cmp_val(ch0_on, regs[SLOT_CHAN0_SINGLE_ENDED_ON][BIT_CH0_ON]);
    cmp_val(slew, regs[SLOT_CH0_SLEW][SLEW_W-1:0]);
    for (int c = 0; c < NUM_CHAN; c++) begin
      cmp_val(cm[c], regs[CH_CTRL_SLOT[c]][CURRENT_MODE_BIT[c]]);
      cmp_val(ls[c], regs[CH_BUF_SLOT[c]][LOW_SWING_BIT[c]]);
      cmp_val(pl[c], HAS_CMOS_LEGS[c] & regs[CH_BUF_SLOT[c]][POS_ON_BIT[c]]);
      cmp_val(nl[c], HAS_CMOS_LEGS[c] & regs[CH_BUF_SLOT[c]][NEG_ON_BIT[c]]);
    end
    for (int s = 1; s < NUM_REGS; s++) wr(REG_OFS[s], 16'h0000);
    // mute at level zero seen through per-leg inversion
    wr(7'h39, 16'h0001);
    wr(7'h3F, 16'h0003);
    wr(7'h3B, 16'h2800);
    tick(4);
    cmp_val({pos[1:0], neg[0]}, 3'h7);
    wr(7'h3B, 16'h5000);
    tick(4);
    cmp_val({pos[1:0], neg[0]}, 3'h4);
    wr(7'h3B, 16'h0000);
    wr(7'h3F, 16'h0000);
    wr(7'h39, 16'h0000);
    tick(10);
    snap = rises;
    tick(40);
    for (int c = 0; c < NUM_CHAN; c++) cmp_val(rises[c] - snap[c], 16'(40 / div[c]));
    // alignment: one-cycle glitch, hold, staggered release
    wr(7'h39, 16'h0008);
    wr(7'h3F, 16'h0008);
    wr(7'h44, 16'h0008);
    pin_n <= 1'b0;
    tick(1);
    pin_n <= 1'b1;
    repeat (6) begin
      tick(1);
      cmp_val(hold, 1'b0);
    end
    pin_n <= 1'b0;
    tick(12);
    cmp_val(run, 4'h8);
    cmp_val(pos[2:0], 3'h0);
    t = '{-1, -2, -3};
    pin_n <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk_sys_i);
      for (int c = 0; c < 3; c++) if (pos[c] === 1'b1 && t[c] < 0) t[c] = k;
    end
    cmp_val(16'(t[2] - t[0]), 16'h0000);
    cmp_val(16'(t[1] - t[0]), 16'(SYNC_DELAY_MAX));
    wr(7'h00, 16'h4000);
    tick(3);
    cmp_val(hold, 1'b1);
    wr(7'h00, 16'h0020);
    pin_n <= 1'b0;
    tick(6);
    cmp_val({pd, hold}, 2'h2);
    pin_n <= 1'b1;
    wr(7'h00, DEV_CTRL0_RST);
    wr(7'h39, 16'h0000);
    wr(7'h3F, 16'h0000);
    wr(7'h44, 16'h0200);
    div[2] <= 14'h0008;
    tick(20);
    // divider shortened in the middle of a high phase
    wait_lvl(2, 0);
    wait_lvl(2, 1);
    tick(1);
    div[2] <= 14'h0002;
    wait_lvl(2, 0);
    wait_lvl(2, 1);
    tick(1);
    cmp_val(hi_len[2], 16'h0004);
    cmp_val(lo_len[2], 16'h0005);
    // individual and global output enable
    wr(7'h4E, 16'h1000);
    wait_lvl(1, 0);
    wait_lvl(1, 1);
    chan_oe_i[1] <= 1'b0;
    tick(1);
    snap = rises;
    tick(40);
    cmp_val(rises[1] - snap[1], 16'h0004);
    cmp_val({act[1], pos[1]}, 2'h0);
    chan_oe_i[1] <= 1'b1;
    for (k = 0; k < 30 && pos[1] !== 1'b1; k++) @(posedge clk_sys_i);
    cmp_val(k >= 4 && k < 30, 1'b1);
    global_oe_i <= 1'b0;
    tick(60);
    cmp_val(act, 4'h0);
    global_oe_i <= 1'b1;
    tick(60);
    cmp_val(act, 4'hF);
    conclude();
  end
endmodule
